// *** fsif_tag_cell.sv ***
/*
 * Shared constants of the state image formatter and the per-register tag cell.
 * Assumes one core clock; the cell is purely combinational.
 */
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Tag byte at byte 4, byte 5 zero.
// - Control, status, opcode at bytes 0-3, 6-7.
// - Instruction pointer 64-bit, or 32-bit plus selector.
// - Data pointer 64-bit, or 32-bit plus selector.
// - Data pointer free when no memory operand.
// - Media control word stored only when enabled.
// - Support mask at bytes 28-31, bit 6 flush.
// - Reserved media control bit set raises protection fault.
// - Eight stack-ordered 16-byte slots, upper six reserved.
// - Vector registers stored only when enabled.
// - Two-bit tags reduce to occupied or empty.
// - Lazy flag set faults media instructions.
// - Legacy task switch sets lazy flag.
// - Long mode never sets lazy flag itself.
// - Image is ordinary read-write memory.
package fsif_pkg;
    localparam logic [7:0] ADDR_IMAGE_LAST = 8'h7f;
    localparam logic [7:0] ADDR_COMMAND = 8'h80;
    localparam logic [7:0] ADDR_LAZY = 8'h81;
    localparam logic [7:0] ADDR_MEDIA_CTRL = 8'h82;
    localparam logic [7:0] ADDR_X87_VIEW = 8'h83;
    localparam int CMD_STORE_BIT = 0;
    localparam int CMD_LOAD_BIT = 1;
    localparam int CMD_FMT64_BIT = 2;
    localparam logic [6:0] WORD_CTRL_STATUS = 7'h00;
    localparam logic [6:0] WORD_TAG_OPCODE = 7'h01;
    localparam logic [6:0] WORD_IP_LO = 7'h02;
    localparam logic [6:0] WORD_IP_HI = 7'h03;
    localparam logic [6:0] WORD_DP_LO = 7'h04;
    localparam logic [6:0] WORD_DP_HI = 7'h05;
    localparam logic [6:0] WORD_MEDIA_CTRL = 7'h06;
    localparam logic [6:0] WORD_SUPPORT_MASK = 7'h07;
    localparam logic [6:0] WORD_STACK_FIRST = 7'h08;
    localparam logic [6:0] WORD_VECTOR_FIRST = 7'h28;
    localparam logic [6:0] WORD_LAST = 7'h47;
    localparam int TOP_LSB = 11;
    localparam logic [15:0] RESET_CONTROL_WORD = 16'h037f;
    localparam logic [15:0] RESET_TAG_WORD = 16'hffff;
    localparam logic [31:0] RESET_MEDIA_CTRL = 32'h0000_0000;
    localparam logic [31:0] SUPPORT_MASK = 32'h0000_ffff;
    localparam int FLUSH_ZERO_BIT = 6;
    typedef enum logic [1:0] {
        FSIF_IDLE = 2'b00,
        FSIF_STORE = 2'b01,
        FSIF_LOAD = 2'b10,
        FSIF_FINISH = 2'b11
    } fsif_phase_type;
endpackage

module fsif_tag_cell (
    input wire logic [1:0] tag2_i,     // Full two-bit tag
    input wire logic abridged_i,       // Abridged tag bit from an image
    input wire logic [79:0] value_i,   // Register contents
    output logic abridged_o,           // Occupied bit for the image
    output logic [1:0] tag2_o          // Tag rebuilt from contents
);
    logic [14:0] exponent;
    logic j_bit;
    logic frac_zero;

    assign exponent = value_i[78:64];
    assign j_bit = value_i[63];
    assign frac_zero = (value_i[62:0] == 63'h0);
    assign abridged_o = (tag2_i != 2'b11);

    // Classification used by a load to restore the full tag.
    always_comb
    begin
        if (!abridged_i)
            tag2_o = 2'b11;
        else if (exponent == 15'h0)
            tag2_o = (!j_bit && frac_zero) ? 2'b01 : 2'b10;
        else if (exponent == 15'h7fff)
            tag2_o = 2'b10;
        else
            tag2_o = j_bit ? 2'b00 : 2'b10;
    end
endmodule

`default_nettype wire

// *** fsif_formatter.sv ***
/*
 * State image formatter: holds the x87 and media state, builds the 288-byte
 * store image into a word memory and reads it back on a load.
 * Assumes all inputs come from logic on core_clk_i and software uses the plain
 * register port.
 */
`timescale 1ns/10ps
`default_nettype none

module fsif_formatter (
    input wire logic core_clk_i,                    // Core clock
    input wire logic rst_i,                         // Asynchronous reset
    input wire logic [7:0] addr_i,                  // Register word address
    input wire logic [31:0] wr_data_i,              // Write data
    input wire logic wr_i,                          // Write strobe
    input wire logic rd_i,                          // Read strobe
    output logic [31:0] rd_data_o,                  // Read data, next cycle
    input wire logic long_mode_i,                   // Long mode active
    input wire logic os_media_save_enable_i,        // Media save enable
    input wire logic task_switch_i,                 // Hardware task switch
    input wire logic issue_i,                       // Instruction issue pulse
    input wire logic issue_x87_i,                   // Issue is x87
    input wire logic issue_media64_i,               // Issue is 64-bit media
    input wire logic issue_media128_i,              // Issue is 128-bit media
    input wire logic issue_control_i,               // Issue is x87 control
    input wire logic issue_mem_i,                   // Issue has memory operand
    input wire logic [10:0] issue_opcode_i,         // Issue opcode
    input wire logic [63:0] issue_ip_i,             // Issue instruction offset
    input wire logic [15:0] issue_cs_i,             // Issue code selector
    input wire logic [63:0] issue_dp_i,             // Issue data offset
    input wire logic [15:0] issue_ds_i,             // Issue data selector
    output logic lazy_switch_flag_o,                // Lazy switch flag
    output logic device_unavailable_fault_o,        // Fault pulse
    output logic general_protection_fault_o,        // Fault pulse
    output logic busy_o                             // Store or load running
);
    import fsif_pkg::*;

    typedef struct packed {
        logic [15:0] x87_control_word;
        logic [15:0] x87_status_word;
        logic [15:0] tag_word;
        logic [10:0] last_x87_opcode;
        logic [63:0] instr_offset64;
        logic [15:0] code_selector;
        logic [63:0] data_offset64;
        logic [15:0] data_selector;
        logic [31:0] media_ctrl_status;
        logic [7:0][79:0] x87_data_reg;
        logic [7:0][127:0] media_vector_reg;
        logic [7:0] abridged_tag_byte;
        logic [31:0] loaded_media_ctrl;
        logic lazy_switch_flag;
        fsif_phase_type phase;
        logic fmt64;
        logic [6:0] word_idx;
        logic [31:0] rd_data;
        logic nm_fault;
        logic gp_fault;
    } fsif_state_type;

    fsif_state_type st_reg;
    fsif_state_type st_next;
    logic [31:0] image_mem [0:127];
    logic mem_we;
    logic [6:0] mem_wa;
    logic [31:0] mem_wd;
    logic [31:0] mem_rd;
    logic [7:0] abr_now;
    logic [7:0][1:0] tag_rebuilt;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_cell
            fsif_tag_cell u_cell (
                .tag2_i(st_reg.tag_word[2*gi+1:2*gi]),
                .abridged_i(st_reg.abridged_tag_byte[gi]),
                .value_i(st_reg.x87_data_reg[gi]),
                .abridged_o(abr_now[gi]),
                .tag2_o(tag_rebuilt[gi])
            );
        end
    endgenerate

    assign mem_rd = image_mem[st_reg.word_idx];

    always_ff @(posedge core_clk_i)
    begin
        if (mem_we)
            image_mem[mem_wa] <= mem_wd;
    end

    always_comb
    begin
        logic [6:0] rel;
        logic [2:0] slot;
        logic [2:0] phys;
        logic [1:0] part;
        logic [31:0] word;
        logic write_word;
        logic image_hit;
        logic [79:0] sreg;
        logic [127:0] vreg;
        rel = 7'h0;
        slot = 3'h0;
        phys = 3'h0;
        part = 2'h0;
        word = 32'h0;
        write_word = 1'b0;
        image_hit = (addr_i <= ADDR_IMAGE_LAST);
        sreg = 80'h0;
        vreg = 128'h0;
        st_next = st_reg;
        st_next.rd_data = 32'h0;
        st_next.nm_fault = 1'b0;
        st_next.gp_fault = 1'b0;
        mem_we = 1'b0;
        mem_wa = addr_i[6:0];
        mem_wd = wr_data_i;

        if (st_reg.word_idx >= WORD_VECTOR_FIRST)
            rel = st_reg.word_idx - WORD_VECTOR_FIRST;
        else
            rel = st_reg.word_idx - WORD_STACK_FIRST;
        slot = rel[4:2];
        part = rel[1:0];
        phys = slot + st_reg.x87_status_word[TOP_LSB+2:TOP_LSB];
        sreg = st_reg.x87_data_reg[phys];
        vreg = st_reg.media_vector_reg[slot];

        // Software access; image writes are dropped while a store owns the memory.
        if (rd_i)
        begin
            if (image_hit)
                st_next.rd_data = image_mem[addr_i[6:0]];
            else if (addr_i == ADDR_COMMAND)
                st_next.rd_data = {31'h0, st_reg.phase != FSIF_IDLE};
            else if (addr_i == ADDR_LAZY)
                st_next.rd_data = {31'h0, st_reg.lazy_switch_flag};
            else if (addr_i == ADDR_MEDIA_CTRL)
                st_next.rd_data = st_reg.media_ctrl_status;
            else if (addr_i == ADDR_X87_VIEW)
                st_next.rd_data = {st_reg.tag_word, st_reg.x87_control_word};
        end
        if (wr_i && image_hit && st_reg.phase != FSIF_STORE)
            mem_we = 1'b1;
        if (wr_i && addr_i == ADDR_LAZY)
            st_next.lazy_switch_flag = wr_data_i[0];
        if (wr_i && addr_i == ADDR_MEDIA_CTRL)
        begin
            if ((wr_data_i & ~SUPPORT_MASK) != 32'h0)
                st_next.gp_fault = 1'b1;
            else
                st_next.media_ctrl_status = wr_data_i;
        end
        if (task_switch_i && !long_mode_i)
            st_next.lazy_switch_flag = 1'b1;

        if (issue_i && (issue_x87_i || issue_media64_i || issue_media128_i))
        begin
            if (st_reg.lazy_switch_flag)
                st_next.nm_fault = 1'b1;
            else if (issue_x87_i && !issue_control_i)
            begin
                st_next.last_x87_opcode = issue_opcode_i;
                st_next.instr_offset64 = issue_ip_i;
                st_next.code_selector = issue_cs_i;
                if (issue_mem_i)
                begin
                    st_next.data_offset64 = issue_dp_i;
                    st_next.data_selector = issue_ds_i;
                end
            end
        end

        case (st_reg.phase)
            FSIF_IDLE:
            begin
                if (wr_i && addr_i == ADDR_COMMAND)
                begin
                    st_next.fmt64 = long_mode_i && wr_data_i[CMD_FMT64_BIT];
                    st_next.word_idx = WORD_CTRL_STATUS;
                    if (wr_data_i[CMD_STORE_BIT])
                        st_next.phase = FSIF_STORE;
                    else if (wr_data_i[CMD_LOAD_BIT])
                        st_next.phase = FSIF_LOAD;
                end
            end
            FSIF_STORE:
            begin
                write_word = 1'b1;
                if (st_reg.word_idx == WORD_CTRL_STATUS)
                    word = {st_reg.x87_status_word, st_reg.x87_control_word};
                else if (st_reg.word_idx == WORD_TAG_OPCODE)
                    word = {5'h0, st_reg.last_x87_opcode, 8'h00, abr_now};
                else if (st_reg.word_idx == WORD_IP_LO)
                    word = st_reg.instr_offset64[31:0];
                else if (st_reg.word_idx == WORD_IP_HI)
                    word = st_reg.fmt64 ? st_reg.instr_offset64[63:32] :
                        {16'h0, st_reg.code_selector};
                else if (st_reg.word_idx == WORD_DP_LO)
                    word = st_reg.data_offset64[31:0];
                else if (st_reg.word_idx == WORD_DP_HI)
                    word = st_reg.fmt64 ? st_reg.data_offset64[63:32] :
                        {16'h0, st_reg.data_selector};
                else if (st_reg.word_idx == WORD_MEDIA_CTRL)
                begin
                    word = st_reg.media_ctrl_status;
                    write_word = os_media_save_enable_i;
                end
                else if (st_reg.word_idx == WORD_SUPPORT_MASK)
                    word = SUPPORT_MASK;
                else if (st_reg.word_idx < WORD_VECTOR_FIRST)
                begin
                    case (part)
                        2'd0: word = sreg[31:0];
                        2'd1: word = sreg[63:32];
                        2'd2: word = {16'h0, sreg[79:64]};
                        default: word = 32'h0;
                    endcase
                end
                else
                begin
                    word = vreg[32*part +: 32];
                    write_word = os_media_save_enable_i;
                end
                mem_we = write_word;
                mem_wa = st_reg.word_idx;
                mem_wd = word;
                st_next.word_idx = st_reg.word_idx + 7'h1;
                if (st_reg.word_idx == WORD_LAST)
                    st_next.phase = FSIF_IDLE;
            end
            FSIF_LOAD:
            begin
                if (st_reg.word_idx == WORD_CTRL_STATUS)
                begin
                    st_next.x87_control_word = mem_rd[15:0];
                    st_next.x87_status_word = mem_rd[31:16];
                end
                else if (st_reg.word_idx == WORD_TAG_OPCODE)
                begin
                    st_next.abridged_tag_byte = mem_rd[7:0];
                    st_next.last_x87_opcode = mem_rd[26:16];
                end
                else if (st_reg.word_idx == WORD_IP_LO)
                    st_next.instr_offset64[31:0] = mem_rd;
                else if (st_reg.word_idx == WORD_IP_HI)
                begin
                    if (st_reg.fmt64)
                        st_next.instr_offset64[63:32] = mem_rd;
                    else
                    begin
                        st_next.instr_offset64[63:32] = 32'h0;
                        st_next.code_selector = mem_rd[15:0];
                    end
                end
                else if (st_reg.word_idx == WORD_DP_LO)
                    st_next.data_offset64[31:0] = mem_rd;
                else if (st_reg.word_idx == WORD_DP_HI)
                begin
                    if (st_reg.fmt64)
                        st_next.data_offset64[63:32] = mem_rd;
                    else
                    begin
                        st_next.data_offset64[63:32] = 32'h0;
                        st_next.data_selector = mem_rd[15:0];
                    end
                end
                else if (st_reg.word_idx == WORD_MEDIA_CTRL)
                    st_next.loaded_media_ctrl = mem_rd;
                else if (st_reg.word_idx == WORD_SUPPORT_MASK)
                    st_next.loaded_media_ctrl = st_reg.loaded_media_ctrl;
                else if (st_reg.word_idx < WORD_VECTOR_FIRST)
                begin
                    case (part)
                        2'd0: st_next.x87_data_reg[phys][31:0] = mem_rd;
                        2'd1: st_next.x87_data_reg[phys][63:32] = mem_rd;
                        2'd2: st_next.x87_data_reg[phys][79:64] = mem_rd[15:0];
                        default: st_next.x87_data_reg[phys][79:64] = sreg[79:64];
                    endcase
                end
                else if (os_media_save_enable_i)
                    st_next.media_vector_reg[slot][32*part +: 32] = mem_rd;
                st_next.word_idx = st_reg.word_idx + 7'h1;
                if (st_reg.word_idx == WORD_LAST)
                    st_next.phase = FSIF_FINISH;
            end
            FSIF_FINISH:
            begin
                st_next.tag_word = tag_rebuilt;
                if (os_media_save_enable_i)
                begin
                    if ((st_reg.loaded_media_ctrl & ~SUPPORT_MASK) != 32'h0)
                        st_next.gp_fault = 1'b1;
                    else
                        st_next.media_ctrl_status = st_reg.loaded_media_ctrl;
                end
                st_next.phase = FSIF_IDLE;
            end
            default:
            begin
                st_next.phase = FSIF_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_reg <= '0;
            st_reg.x87_control_word <= RESET_CONTROL_WORD;
            st_reg.tag_word <= RESET_TAG_WORD;
            st_reg.media_ctrl_status <= RESET_MEDIA_CTRL;
            st_reg.phase <= FSIF_IDLE;
        end
        else
            st_reg <= st_next;
    end

    assign rd_data_o = st_reg.rd_data;
    assign lazy_switch_flag_o = st_reg.lazy_switch_flag;
    assign device_unavailable_fault_o = st_reg.nm_fault;
    assign general_protection_fault_o = st_reg.gp_fault;
    assign busy_o = (st_reg.phase != FSIF_IDLE);
endmodule

`default_nettype wire

// *** fsif_formatter_asserts.sv ***
/*
 * Checker for the state image formatter: fault pulses, lazy flag, busy span, read data.
 * Assumes it is bound to fsif_formatter and sees only that module's ports.
 */
`timescale 1ns/10ps
`default_nettype none

module fsif_formatter_asserts (
    input wire logic core_clk_i,                // Core clock
    input wire logic rst_i,                     // Asynchronous reset
    input wire logic [7:0] addr_i,              // Word address
    input wire logic [31:0] wr_data_i,          // Write data
    input wire logic wr_i,                      // Write strobe
    input wire logic rd_i,                      // Read strobe
    input wire logic [31:0] rd_data_o,          // Read data
    input wire logic long_mode_i,               // Long mode
    input wire logic task_switch_i,             // Task switch pulse
    input wire logic issue_i,                   // Issue pulse
    input wire logic issue_x87_i,               // Issue is x87
    input wire logic issue_media64_i,           // Issue is 64-bit media
    input wire logic issue_media128_i,          // Issue is 128-bit media
    input wire logic lazy_switch_flag_o,        // Lazy flag
    input wire logic device_unavailable_fault_o, // Fault pulse
    input wire logic general_protection_fault_o, // Fault pulse
    input wire logic busy_o                     // Busy
);
    import fsif_pkg::*;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_gp_reserved;
        wr_i && addr_i == ADDR_MEDIA_CTRL && |(wr_data_i & ~SUPPORT_MASK)
            |=> general_protection_fault_o;
    endproperty
    a_gp_reserved: assert property (p_gp_reserved)
        else $error("reserved media bit write gave no fault");
    property p_nm_lazy;
        issue_i && (issue_x87_i || issue_media64_i || issue_media128_i) && lazy_switch_flag_o
            |=> device_unavailable_fault_o;
    endproperty
    a_nm_lazy: assert property (p_nm_lazy)
        else $error("issue under lazy flag gave no fault");
    property p_nm_clear;
        !lazy_switch_flag_o |=> !device_unavailable_fault_o;
    endproperty
    a_nm_clear: assert property (p_nm_clear)
        else $error("unavailable fault without lazy flag");
    property p_task_set;
        task_switch_i && !long_mode_i |=> lazy_switch_flag_o;
    endproperty
    a_task_set: assert property (p_task_set)
        else $error("legacy task switch left lazy flag clear");
    property p_task_long;
        task_switch_i && long_mode_i && !(wr_i && addr_i == ADDR_LAZY)
            |=> $stable(lazy_switch_flag_o);
    endproperty
    a_task_long: assert property (p_task_long)
        else $error("long mode task switch changed lazy flag");
    property p_lazy_wr;
        wr_i && addr_i == ADDR_LAZY && !task_switch_i
            |=> lazy_switch_flag_o == $past(wr_data_i[0]);
    endproperty
    a_lazy_wr: assert property (p_lazy_wr)
        else $error("lazy flag does not follow software write");
    property p_store_len;
        wr_i && addr_i == ADDR_COMMAND && wr_data_i[CMD_STORE_BIT] && !busy_o
            |-> ##1 busy_o ##71 busy_o ##1 !busy_o;
    endproperty
    a_store_len: assert property (p_store_len)
        else $error("store span is not 72 cycles");
    property p_load_len;
        wr_i && addr_i == ADDR_COMMAND && wr_data_i[CMD_LOAD_BIT] && !wr_data_i[CMD_STORE_BIT]
            && !busy_o |-> ##1 busy_o ##72 busy_o ##1 !busy_o;
    endproperty
    a_load_len: assert property (p_load_len)
        else $error("load span is not 73 cycles");
    property p_rd_idle;
        !rd_i |=> rd_data_o == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its cycle");
endmodule

bind fsif_formatter fsif_formatter_asserts u_chk (.core_clk_i, .rst_i, .addr_i, .wr_data_i,
    .wr_i, .rd_i, .rd_data_o, .long_mode_i, .task_switch_i, .issue_i, .issue_x87_i,
    .issue_media64_i, .issue_media128_i, .lazy_switch_flag_o, .device_unavailable_fault_o,
    .general_protection_fault_o, .busy_o);

`default_nettype wire

// *** fsif_formatter_tb.sv ***
/*
 * Self-checking testbench of the state image formatter.
 * Assumes the package and formatter are compiled first; the checker is bound.
 */
`timescale 1ns/10ps
`default_nettype none

module fsif_formatter_tb;
    import fsif_pkg::*;
    logic core_clk_i, rst_i, wr_i, rd_i, long_mode_i, os_media_save_enable_i, task_switch_i;
    logic issue_i, issue_x87_i, issue_media64_i, issue_media128_i, issue_control_i, issue_mem_i;
    logic [7:0] addr_i;
    logic [31:0] wr_data_i, rd_data_o;
    logic [10:0] issue_opcode_i;
    logic [63:0] issue_ip_i, issue_dp_i;
    logic lazy_switch_flag_o, device_unavailable_fault_o, general_protection_fault_o, busy_o;
    int miscompares, n_tests;

    fsif_formatter uut (.core_clk_i, .rst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
        .long_mode_i, .os_media_save_enable_i, .task_switch_i, .issue_i, .issue_x87_i,
        .issue_media64_i, .issue_media128_i, .issue_control_i, .issue_mem_i, .issue_opcode_i,
        .issue_ip_i, .issue_cs_i(issue_ip_i[63:48]), .issue_dp_i,
        .issue_ds_i(issue_dp_i[63:48]), .lazy_switch_flag_o, .device_unavailable_fault_o,
        .general_protection_fault_o, .busy_o);

    always #12.5 core_clk_i = ~core_clk_i;

    task automatic end_sim();
        $display("comparisons=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic fchk(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rd_data_o, exp);
    endtask
    task automatic mode(input logic lm, input logic en);
        @(posedge core_clk_i);
        long_mode_i <= lm;
        os_media_save_enable_i <= en;
    endtask
    // Starts a command and waits, bounded, until the block is idle again.
    task automatic run(input logic [31:0] cmd);
        int n;
        n = 0;
        wr(ADDR_COMMAND, cmd);
        while (busy_o === 1'b1 && n < 200)
        begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        fchk(busy_o, 1'b0);
    endtask
    task automatic issue(input logic [3:0] kind, input logic mem, input logic [10:0] op,
                         input logic [63:0] ip, input logic [63:0] dp);
        @(posedge core_clk_i);
        issue_i <= 1'b1;
        {issue_control_i, issue_media128_i, issue_media64_i, issue_x87_i} <= kind;
        issue_mem_i <= mem;
        issue_opcode_i <= op;
        issue_ip_i <= ip;
        issue_dp_i <= dp;
        @(posedge core_clk_i);
        issue_i <= 1'b0;
        #1;
    endtask
    task automatic tswitch(input logic lm);
        @(posedge core_clk_i);
        long_mode_i <= lm;
        task_switch_i <= 1'b1;
        @(posedge core_clk_i);
        task_switch_i <= 1'b0;
        #1;
    endtask

    task automatic t_reset_and_media();
        rchk(ADDR_X87_VIEW, {RESET_TAG_WORD, RESET_CONTROL_WORD});
        rchk(ADDR_MEDIA_CTRL, RESET_MEDIA_CTRL);
        wr(8'h84, 32'hffff_ffff);
        rchk(8'h84, 32'h0000_0000);
        wr(ADDR_MEDIA_CTRL, 32'hffff_ffff & SUPPORT_MASK);
        fchk(general_protection_fault_o, 1'b0);
        rchk(ADDR_MEDIA_CTRL, 32'h0000_ffff);
        wr(ADDR_MEDIA_CTRL, 32'h0000_1f80);
        wr(ADDR_MEDIA_CTRL, 32'h0001_1f80);
        fchk(general_protection_fault_o, 1'b1);
        rchk(ADDR_MEDIA_CTRL, 32'h0000_1f80);
    endtask
    task automatic t_store32();
        mode(1'b0, 1'b1);
        issue(4'h1, 1'b1, 11'h5a3, 64'h0ab1_2222_3333_4444, 64'h0cd2_6666_7777_8888);
        fchk(device_unavailable_fault_o, 1'b0);
        run(32'h0000_0001);
        rchk(8'h00, 32'h0000_037f);
        rchk(8'h01, 32'h05a3_0000);
        rchk(8'h02, 32'h3333_4444);
        rchk(8'h03, 32'h0000_0ab1);
        rchk(8'h04, 32'h7777_8888);
        rchk(8'h05, 32'h0000_0cd2);
        rchk(8'h06, 32'h0000_1f80);
        rchk(8'h07, SUPPORT_MASK);
        rchk(8'h0b, 32'h0000_0000);
        rchk(ADDR_COMMAND, 32'h0000_0000);
    endtask
    task automatic t_store64();
        mode(1'b1, 1'b0);
        wr(8'h06, 32'hdead_beef);
        wr(8'h28, 32'h1234_5678);
        issue(4'h1, 1'b0, 11'h111, 64'h0123_4567_89ab_cdef, 64'h0fff_0000_0000_0001);
        issue(4'h9, 1'b1, 11'h7ff, 64'h0, 64'h0);
        run(32'h0000_0005);
        rchk(8'h01, 32'h0111_0000);
        rchk(8'h02, 32'h89ab_cdef);
        rchk(8'h03, 32'h0123_4567);
        rchk(8'h04, 32'h7777_8888);
        rchk(8'h05, 32'h0cd2_6666);
        rchk(8'h06, 32'hdead_beef);
        rchk(8'h28, 32'h1234_5678);
    endtask
    task automatic t_load();
        mode(1'b0, 1'b1);
        wr(8'h00, 32'h0000_027f);
        wr(8'h01, 32'h0000_0003);
        wr(8'h06, 32'h0001_1f80);
        wr(8'h0d, 32'h8000_0000);
        wr(8'h0e, 32'h0000_0001);
        run(32'h0000_0002);
        fchk(general_protection_fault_o, 1'b1);
        rchk(ADDR_X87_VIEW, 32'hfff1_027f);
        rchk(ADDR_MEDIA_CTRL, 32'h0000_1f80);
        run(32'h0000_0001);
        rchk(8'h00, 32'h0000_027f);
        rchk(8'h01, 32'h0000_0003);
    endtask
    task automatic t_lazy();
        wr(ADDR_LAZY, 32'h0000_0001);
        fchk(lazy_switch_flag_o, 1'b1);
        for (int k = 0; k < 3; k++)
        begin
            issue(4'(1 << k), 1'b0, 11'h0aa, 64'h0, 64'h0);
            fchk(device_unavailable_fault_o, 1'b1);
        end
        wr(ADDR_LAZY, 32'h0000_0000);
        issue(4'h1, 1'b0, 11'h0aa, 64'h0, 64'h0);
        fchk(device_unavailable_fault_o, 1'b0);
        tswitch(1'b1);
        fchk(lazy_switch_flag_o, 1'b0);
        tswitch(1'b0);
        fchk(lazy_switch_flag_o, 1'b1);
        rchk(ADDR_LAZY, 32'h0000_0001);
    endtask

    initial
    begin
        core_clk_i = 1'b0;
        rst_i = 1'b1;
        {wr_i, rd_i, long_mode_i, os_media_save_enable_i, task_switch_i} = 5'h00;
        {issue_i, issue_x87_i, issue_media64_i, issue_media128_i} = 4'h0;
        {issue_control_i, issue_mem_i} = 2'b00;
        addr_i = 8'h00;
        wr_data_i = 32'h0;
        issue_opcode_i = 11'h000;
        issue_ip_i = 64'h0;
        issue_dp_i = 64'h0;
        miscompares = 0;
        n_tests = 0;
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        fchk(busy_o, 1'b0);
        t_reset_and_media();
        t_store32();
        t_store64();
        t_load();
        t_lazy();
        end_sim();
    end

    initial
    begin
        repeat (5000) @(posedge core_clk_i);
        miscompares++;
        end_sim();
    end
endmodule

`default_nettype wire
